// [fph_pkg.sv]
/*
  Constants, register map and mode types for the decimation filter back
  end: FIR low-pass sub-stages with phase choice and first-order IIR
  high-pass stage.
  Assumes a single master clock domain and an AXI4-Lite register master.
*/
package fph_pkg;

  localparam int FPH_DW = 32;
  localparam int FPH_AW = 4;

  // Register byte offsets
  localparam logic [3:0] FPH_OFS_CTRL    = 4'h0;
  localparam logic [3:0] FPH_OFS_COEF_LO = 4'h4;
  localparam logic [3:0] FPH_OFS_COEF_HI = 4'h8;
  localparam logic [3:0] FPH_OFS_STATUS  = 4'hc;

  // Field positions
  localparam int FPH_CTRL_PHASE_BIT = 0;
  localparam int FPH_CTRL_CHAIN_LSB = 1;
  localparam int FPH_STAT_MODE_BIT  = 3;
  localparam int FPH_STAT_CNT_LSB   = 16;

  // Reset and fixed values
  localparam logic        FPH_RST_PHASE = 1'b0;
  localparam logic [15:0] FPH_RST_COEF  = 16'h0332;
  localparam logic [15:0] FPH_PIN_COEF  = 16'h0332;
  localparam int          FPH_COEF_SH   = 16;

  // AXI responses
  localparam logic [1:0] FPH_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FPH_RESP_SLVERR = 2'h2;

  // FIR sub-stage layout
  localparam int FPH_NSUB        = 4;
  localparam int FPH_PHASED_FROM = 2;
  localparam int FPH_FIR_RATIO [0:FPH_NSUB-1] = '{2, 2, 4, 2};

  typedef enum logic [1:0] {
    FPH_CH_BYPASS,
    FPH_CH_SINC,
    FPH_CH_FIR,
    FPH_CH_HPF
  } fph_chain_t;

  localparam fph_chain_t FPH_RST_CHAIN = FPH_CH_HPF;

endpackage

// [fph_fir_sub.sv]
/*
  One decimating FIR sub-stage with three taps and an optional
  minimum-phase tap set.
  Assumes samples arrive as one-cycle in_valid pulses on ref_clk.
*/
`timescale 1ns/1ps
module fph_fir_sub import fph_pkg::*; #(
  parameter int RATIO  = 2,
  parameter bit PHASED = 1'b0
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  // Control
  input  wire logic                     min_phase,
  // Sample stream
  input  wire logic                     in_valid,
  input  wire logic signed [FPH_DW-1:0] in_data,
  output logic                          out_valid,
  output logic signed [FPH_DW-1:0]      out_data
);

  localparam logic [2:0] LAST = 3'(RATIO - 1);

  typedef struct packed {
    logic signed [FPH_DW-1:0] x1;
    logic signed [FPH_DW-1:0] x2;
    logic [2:0]               cnt;
    logic                     ov;
    logic signed [FPH_DW-1:0] od;
  } fph_sub_st_t;

  fph_sub_st_t s_ff;
  fph_sub_st_t nxt_s;
  logic signed [FPH_DW+1:0] t0, t1, t2, acc;
  logic use_min;

  assign use_min = PHASED && min_phase;

  always_comb begin
    nxt_s = s_ff;
    t0 = (FPH_DW+2)'(in_data);
    t1 = (FPH_DW+2)'(s_ff.x1);
    t2 = (FPH_DW+2)'(s_ff.x2);
    acc = use_min ? (t0 + t0 + t1 + t2) : (t0 + t1 + t1 + t2);
    nxt_s.ov = 1'b0;
    if (in_valid) begin
      nxt_s.x1 = in_data;
      nxt_s.x2 = s_ff.x1;
      if (s_ff.cnt == LAST) begin
        nxt_s.cnt = 3'h0;
        nxt_s.ov  = 1'b1;
        nxt_s.od  = acc[FPH_DW+1:2];
      end else begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign out_valid = s_ff.ov;
  assign out_data  = s_ff.od;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_decim_out;
    clk_en && in_valid && s_ff.cnt == LAST |=> out_valid;
  endproperty
  a_decim_out: assert property (p_decim_out)
    else $error("sub-stage missed its output");

  property p_decim_quiet;
    clk_en && !(in_valid && s_ff.cnt == LAST) |=> !out_valid;
  endproperty
  a_decim_quiet: assert property (p_decim_quiet)
    else $error("sub-stage output off its ratio");

endmodule

// [fph_stage.sv]
/*
  Filter back end: four FIR sub-stages, first-order IIR high-pass,
  output chain select, pin or register control, AXI4-Lite registers.
  Assumes upstream sinc samples as one-cycle pulses on ref_clk and a
  downstream sink that takes every out_valid pulse.
*/
`timescale 1ns/1ps
module fph_stage import fph_pkg::*; (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  // Control pins
  input  wire logic                     control_mode_select,
  input  wire logic                     phase_select,
  input  wire logic                     bypass_select,
  input  wire logic                     highpass_enable,
  // Sample stream from the sinc stage
  input  wire logic                     in_valid,
  input  wire logic signed [FPH_DW-1:0] in_data,
  // Sample stream to output processing
  output logic                          out_valid,
  output logic signed [FPH_DW-1:0]      out_data,
  // AXI4-Lite write
  input  wire logic [FPH_AW-1:0]        awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // AXI4-Lite read
  input  wire logic [FPH_AW-1:0]        araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready
);

  typedef struct packed {
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     aw_got;
    logic                     w_got;
    logic [FPH_AW-1:0]        awaddr;
    logic [31:0]              wdata;
    logic                     wstrb0;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic                     phase;
    fph_chain_t               chain;
    logic [7:0]               coef_lo;
    logic [7:0]               coef_hi;
    logic signed [FPH_DW-1:0] hx1;
    logic signed [FPH_DW-1:0] hy1;
    logic                     ov;
    logic signed [FPH_DW-1:0] od;
    logic [15:0]              out_cnt;
  } fph_top_st_t;

  function automatic logic fph_cfg_hit(input logic [FPH_AW-1:0] a);
    fph_cfg_hit = (a == FPH_OFS_CTRL) || (a == FPH_OFS_COEF_LO) ||
                  (a == FPH_OFS_COEF_HI);
  endfunction

  fph_top_st_t s_ff;
  fph_top_st_t nxt_s;

  logic                     eff_phase;
  fph_chain_t               eff_chain;
  logic [15:0]              eff_coef;
  logic signed [FPH_DW-1:0] fir_d [0:FPH_NSUB];
  logic [FPH_NSUB:0]        fir_v;
  logic signed [48:0]       hprod;
  logic signed [FPH_DW+2:0] hy_sum;
  logic                     wr_ok;
  logic                     rd_ok;

  //////////////////////////////////////////////////////////////////////////
  // Effective controls from pins or registers

  always_comb begin
    if (control_mode_select) begin
      eff_phase = phase_select;
      eff_coef  = FPH_PIN_COEF;
      if (bypass_select) begin
        eff_chain = FPH_CH_BYPASS;
      end else if (highpass_enable) begin
        eff_chain = FPH_CH_HPF;
      end else begin
        eff_chain = FPH_CH_FIR;
      end
    end else begin
      eff_phase = s_ff.phase;
      eff_chain = s_ff.chain;
      eff_coef  = {s_ff.coef_hi, s_ff.coef_lo};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIR sub-stages

  assign fir_d[0] = in_data;
  assign fir_v[0] = in_valid;

  for (genvar gi = 0; gi < FPH_NSUB; gi++) begin : g_sub
    fph_fir_sub #(
      .RATIO  (FPH_FIR_RATIO[gi]),
      .PHASED (gi >= FPH_PHASED_FROM)
    ) u_sub (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .min_phase (eff_phase),
      .in_valid  (fir_v[gi]),
      .in_data   (fir_d[gi]),
      .out_valid (fir_v[gi+1]),
      .out_data  (fir_d[gi+1])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_s = s_ff;
    hprod = s_ff.hy1 * $signed({1'b0, eff_coef});
    hy_sum = (FPH_DW+3)'(fir_d[FPH_NSUB]) - (FPH_DW+3)'(s_ff.hx1) +
             (FPH_DW+3)'(s_ff.hy1) -
             (FPH_DW+3)'($signed(hprod[48:FPH_COEF_SH]));
    wr_ok = 1'b0;
    rd_ok = 1'b0;

    if (fir_v[FPH_NSUB]) begin
      nxt_s.hx1 = fir_d[FPH_NSUB];
      nxt_s.hy1 = hy_sum[FPH_DW-1:0];
    end

    nxt_s.ov = 1'b0;
    case (eff_chain)
      FPH_CH_BYPASS, FPH_CH_SINC: begin
        if (in_valid) begin
          nxt_s.ov = 1'b1;
          nxt_s.od = in_data;
        end
      end
      FPH_CH_FIR: begin
        if (fir_v[FPH_NSUB]) begin
          nxt_s.ov = 1'b1;
          nxt_s.od = fir_d[FPH_NSUB];
        end
      end
      FPH_CH_HPF: begin
        if (fir_v[FPH_NSUB]) begin
          nxt_s.ov = 1'b1;
          nxt_s.od = hy_sum[FPH_DW-1:0];
        end
      end
      default: begin
        nxt_s.ov = 1'b0;
      end
    endcase
    if (nxt_s.ov) begin
      nxt_s.out_cnt = s_ff.out_cnt + 16'h1;
    end

    // Write address and data, taken in either order
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.awready && awvalid) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = awaddr;
    end
    if (s_ff.wready && wvalid) begin
      nxt_s.w_got  = 1'b1;
      nxt_s.wdata  = wdata;
      nxt_s.wstrb0 = wstrb[0];
    end
    if (nxt_s.aw_got && nxt_s.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      // no writable registers in pin mode
      wr_ok = !control_mode_select && fph_cfg_hit(nxt_s.awaddr);
      nxt_s.bresp = wr_ok ? FPH_RESP_OKAY : FPH_RESP_SLVERR;
      if (wr_ok && nxt_s.wstrb0) begin
        case (nxt_s.awaddr)
          FPH_OFS_CTRL: begin
            nxt_s.phase = nxt_s.wdata[FPH_CTRL_PHASE_BIT];
            nxt_s.chain = fph_chain_t'(
              nxt_s.wdata[FPH_CTRL_CHAIN_LSB +: 2]);
          end
          FPH_OFS_COEF_LO: nxt_s.coef_lo = nxt_s.wdata[7:0];
          FPH_OFS_COEF_HI: nxt_s.coef_hi = nxt_s.wdata[7:0];
          default: nxt_s.coef_lo = s_ff.coef_lo;
        endcase
      end
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready  = !nxt_s.w_got && !nxt_s.bvalid;

    // Read channel
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_ff.arready && arvalid) begin
      rd_ok = (araddr == FPH_OFS_STATUS) ||
              (!control_mode_select && fph_cfg_hit(araddr));
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = rd_ok ? FPH_RESP_OKAY : FPH_RESP_SLVERR;
      nxt_s.rdata  = 32'h0;
      if (rd_ok) begin
        case (araddr)
          FPH_OFS_CTRL:    nxt_s.rdata = {29'h0, s_ff.chain, s_ff.phase};
          FPH_OFS_COEF_LO: nxt_s.rdata = {24'h0, s_ff.coef_lo};
          FPH_OFS_COEF_HI: nxt_s.rdata = {24'h0, s_ff.coef_hi};
          default: begin
            nxt_s.rdata[FPH_STAT_CNT_LSB +: 16] = s_ff.out_cnt;
            nxt_s.rdata[FPH_STAT_MODE_BIT] = control_mode_select;
            nxt_s.rdata[2:1] = eff_chain;
            nxt_s.rdata[0]   = eff_phase;
          end
        endcase
      end
    end
    nxt_s.arready = !nxt_s.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  // every stage steps on the master clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_ff         <= '0;
      s_ff.awready <= 1'b1;
      s_ff.wready  <= 1'b1;
      s_ff.arready <= 1'b1;
      s_ff.phase   <= FPH_RST_PHASE;
      s_ff.chain   <= FPH_RST_CHAIN;
      s_ff.coef_lo <= FPH_RST_COEF[7:0];
      s_ff.coef_hi <= FPH_RST_COEF[15:8];
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign out_valid = s_ff.ov;
  assign out_data  = s_ff.od;
  assign awready   = s_ff.awready;
  assign wready    = s_ff.wready;
  assign bvalid    = s_ff.bvalid;
  assign bresp     = s_ff.bresp;
  assign arready   = s_ff.arready;
  assign rvalid    = s_ff.rvalid;
  assign rresp     = s_ff.rresp;
  assign rdata     = s_ff.rdata;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_pin_coef;
    control_mode_select |-> eff_coef == FPH_PIN_COEF;
  endproperty
  a_pin_coef: assert property (p_pin_coef)
    else $error("pin mode coefficient not fixed");

  property p_pin_phase;
    control_mode_select |->
      g_sub[3].u_sub.use_min == phase_select &&
      g_sub[2].u_sub.use_min == phase_select &&
      !g_sub[1].u_sub.use_min && !g_sub[0].u_sub.use_min;
  endproperty
  a_pin_phase: assert property (p_pin_phase)
    else $error("phase pin not steering taps");

  property p_pin_frozen;
    control_mode_select && clk_en |=>
      $stable({s_ff.phase, s_ff.chain, s_ff.coef_lo, s_ff.coef_hi});
  endproperty
  a_pin_frozen: assert property (p_pin_frozen)
    else $error("config changed in pin mode");

  property p_reg_phase;
    !control_mode_select && clk_en && s_ff.awready && awvalid &&
      s_ff.wready && wvalid && wstrb[0] && awaddr == FPH_OFS_CTRL |=>
      s_ff.phase == $past(wdata[FPH_CTRL_PHASE_BIT]) && bvalid;
  endproperty
  a_reg_phase: assert property (p_reg_phase)
    else $error("control write not applied");

  property p_coef_join;
    !control_mode_select |->
      eff_coef[15:8] == s_ff.coef_hi && eff_coef[7:0] == s_ff.coef_lo;
  endproperty
  a_coef_join: assert property (p_coef_join)
    else $error("coefficient bytes misplaced");

  property p_bypass;
    !control_mode_select && s_ff.chain == FPH_CH_BYPASS && in_valid &&
      clk_en |=> out_valid && out_data == $past(in_data);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass sample not passed");

  property p_hpf_dc;
    eff_chain == FPH_CH_HPF && clk_en && fir_v[FPH_NSUB] &&
      fir_d[FPH_NSUB] == s_ff.hx1 && s_ff.hy1 == '0 |=>
      out_valid && out_data == '0;
  endproperty
  a_hpf_dc: assert property (p_hpf_dc)
    else $error("high-pass passed dc");

  property p_fir_only;
    eff_chain == FPH_CH_FIR && clk_en && fir_v[FPH_NSUB] |=>
      out_valid && out_data == $past(fir_d[FPH_NSUB]);
  endproperty
  a_fir_only: assert property (p_fir_only)
    else $error("FIR output not routed");

  c_hpf_out: cover property (eff_chain == FPH_CH_HPF && out_valid);
  c_min_phase: cover property (eff_phase && fir_v[FPH_NSUB]);
  c_wr_done: cover property (bvalid && bready && bresp == FPH_RESP_OKAY);

endmodule

// [fph_far_model.sv]
/*
  Far-side model of the filter back end. An upstream sinc stage sends one
  sample per cycle while run is high. A downstream sink counts the output
  samples.
  Assumes that ref_clk is the master clock of the stage under test.
*/
`timescale 1ns/1ps
module fph_far_model import fph_pkg::*; (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // Bench control
  input  wire logic                     run,
  input  wire logic                     noise,
  input  wire logic signed [FPH_DW-1:0] level,
  // Source side
  output logic                          in_valid,
  output logic signed [FPH_DW-1:0]      in_data,
  // Sink side
  input  wire logic                     out_valid,
  output int unsigned                   out_cnt
);
  ////////////////////////////////////////////////////////////////////////
  // paced by master clock
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in_valid <= 1'b0;
      in_data  <= '0;
    end else if (run) begin
      in_valid <= 1'b1;
      in_data  <= level + (noise ? $signed(32'($urandom) & 32'hff) : 0);
    end else begin
      in_valid <= 1'b0;
      in_data  <= ~in_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // count lets bench skip settling
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_cnt <= 0;
    end else if (out_valid) begin
      out_cnt <= out_cnt + 1;
    end
  end
endmodule

// [fph_stage_tb.sv]
/*
  Self-checking bench for the filter back end: AXI4-Lite register access,
  chain selection, FIR rate and dc gain, high-pass recursion, pin mode.
  Assumes the far-side model for the sample stream.
*/
`timescale 1ns/1ps
module fph_stage_tb import fph_pkg::*;;
  logic ref_clk = 1'b0;
  logic resetn, clk_en, control_mode_select, phase_select;
  logic bypass_select, highpass_enable, in_valid, out_valid;
  logic signed [FPH_DW-1:0] in_data, out_data, level;
  logic [FPH_AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, run, noise;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int unsigned out_cnt;
  int miscompares = 0;
  int checks_done = 0;

  always #2 ref_clk = ~ref_clk;

  fph_stage dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .control_mode_select(control_mode_select), .phase_select(phase_select),
    .bypass_select(bypass_select), .highpass_enable(highpass_enable),
    .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid),
    .out_data(out_data), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  fph_far_model far (.ref_clk(ref_clk), .resetn(resetn), .run(run),
    .noise(noise), .level(level), .in_valid(in_valid), .in_data(in_data),
    .out_valid(out_valid), .out_cnt(out_cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic hang(string what);
    $display("wrong value %s expected handshake seen none", what);
    miscompares++;
    close_out();
  endtask

  // High-pass step for a constant input
  function automatic logic [31:0] hp_next(logic [31:0] y, logic [15:0] c);
    logic [63:0] p;
    p = {{32{y[31]}}, y} * {48'h0, c};
    return y - p[47:16];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) hang("write response");
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic axi_rd(logic [3:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    if (n >= 100) hang("read response");
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  task automatic set_ctrl(logic ph, fph_chain_t ch);
    axi_wr(FPH_OFS_CTRL, {29'h0, ch, ph}, FPH_RESP_OKAY);
  endtask

  task automatic wait_out(output logic [31:0] y);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (out_valid !== 1'b1 && n < 200);
    if (n >= 200) hang("out_valid");
    y = out_data;
  endtask

  // Output equals the sample taken one cycle before
  task automatic pass_check();
    logic [31:0] prev;
    noise <= 1'b1;
    repeat (3) @(posedge ref_clk);
    prev = in_data;
    repeat (20) begin
      @(posedge ref_clk);
      chk("pass valid", 32'h1, 32'(out_valid));
      chk("pass data", prev, out_data);
      prev = in_data;
    end
    noise <= 1'b0;
  endtask

  task automatic hp_pair(logic [15:0] c);
    logic [31:0] y1, y2;
    repeat (4) wait_out(y1);
    wait_out(y2);
    chk("hpf step", hp_next(y1, c), y2);
    if (c == 16'hffff) chk("hpf dc", 32'h1, 32'($signed(y2) < 16));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int unsigned n;
    logic [15:0] c;
    {resetn, clk_en, control_mode_select, phase_select} = 4'b0100;
    {bypass_select, highpass_enable, run, noise} = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb, level} = '0;
    void'($urandom(13487));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    axi_rd(FPH_OFS_CTRL, d, FPH_RESP_OKAY);
    chk("ctrl reset", {29'h0, FPH_RST_CHAIN, FPH_RST_PHASE}, d);
    axi_rd(FPH_OFS_COEF_LO, d, FPH_RESP_OKAY);
    chk("coef lo reset", 32'(FPH_RST_COEF[7:0]), d);
    axi_rd(FPH_OFS_COEF_HI, d, FPH_RESP_OKAY);
    chk("coef hi reset", 32'(FPH_RST_COEF[15:8]), d);
    axi_wr(FPH_OFS_STATUS, 32'h0, FPH_RESP_SLVERR);
    axi_wr(4'h2, 32'h0, FPH_RESP_SLVERR);
    axi_rd(4'h6, d, FPH_RESP_SLVERR);
    chk("unmapped rdata", 32'h0, d);
    run <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      set_ctrl(1'b0, fph_chain_t'(i));
      pass_check();
    end
    level <= 32'sd4096;
    for (int p = 0; p < 2; p++) begin
      set_ctrl(p[0], FPH_CH_FIR);
      repeat (4) wait_out(d);
      chk("fir dc", 32'd4096, d);
      n = out_cnt;
      repeat (256) @(posedge ref_clk);
      chk("fir rate", 32'(n + 8), 32'(out_cnt));
    end
    for (int i = 0; i < 4; i++) begin
      c = (i == 3) ? 16'hffff : 16'($urandom);
      axi_wr(FPH_OFS_COEF_LO, {24'h0, c[7:0]}, FPH_RESP_OKAY);
      axi_wr(FPH_OFS_COEF_HI, {24'h0, c[15:8]}, FPH_RESP_OKAY);
      axi_rd(FPH_OFS_COEF_HI, d, FPH_RESP_OKAY);
      chk("coef hi", {24'h0, c[15:8]}, d);
      set_ctrl(1'b0, FPH_CH_HPF);
      hp_pair(c);
    end
    control_mode_select <= 1'b1;
    highpass_enable <= 1'b1;
    phase_select <= 1'b1;
    axi_rd(FPH_OFS_CTRL, d, FPH_RESP_SLVERR);
    axi_wr(FPH_OFS_COEF_LO, 32'h0, FPH_RESP_SLVERR);
    axi_rd(FPH_OFS_STATUS, d, FPH_RESP_OKAY);
    chk("pin status", 32'hf, d & 32'hf);
    hp_pair(FPH_PIN_COEF);
    bypass_select <= 1'b1;
    pass_check();
    {bypass_select, highpass_enable, phase_select} <= 3'b000;
    axi_rd(FPH_OFS_STATUS, d, FPH_RESP_OKAY);
    chk("pin phase", 32'hc, d & 32'hf);
    control_mode_select <= 1'b0;
    set_ctrl(1'b1, FPH_CH_FIR);
    axi_rd(FPH_OFS_STATUS, d, FPH_RESP_OKAY);
    chk("reg status", 32'h5, d & 32'hf);
    // Stop the stream so the sample count settles
    run <= 1'b0;
    repeat (8) @(posedge ref_clk);
    axi_rd(FPH_OFS_STATUS, d, FPH_RESP_OKAY);
    chk("out count", 32'(16'(out_cnt)), d >> 16);
    close_out();
  end
endmodule
